// *** rtl/srs_pkg.sv ***
// Purpose: Constants and types for the system reset sequencer
// Assumes: Avalon-MM slave, 32-bit data, word addresses on the bus
// Notes: Slow clock ticks come from a divider of core_clk
package srs_pkg;
  // Register byte offsets
  localparam logic [3:0] SRS_OFS_CMD = 4'h0;
  localparam logic [3:0] SRS_OFS_STAT = 4'h4;
  localparam logic [3:0] SRS_OFS_MODE = 4'h8;
  localparam logic [3:0] SRS_OFS_WDOG = 4'hC;
  // Key field
  localparam int SRS_KEY_LSB = 24;
  localparam logic [7:0] SRS_KEY_VAL = 8'hA5;
  // Command bits
  localparam int SRS_CMD_CPU = 0;
  localparam int SRS_CMD_PER = 2;
  localparam int SRS_CMD_PIN = 3;
  // Mode bits
  localparam int SRS_MODE_UEN = 0;
  localparam int SRS_MODE_UIEN = 4;
  localparam int SRS_MODE_LEN_LSB = 8;
  // Watchdog mode bits
  localparam int SRS_WD_EN = 0;
  localparam int SRS_WD_CPU = 1;
  // Status bits
  localparam int SRS_ST_SEEN = 0;
  localparam int SRS_ST_CAUSE_LSB = 8;
  localparam int SRS_ST_LEVEL = 16;
  localparam int SRS_ST_PEND = 17;
  // Reset cause codes
  localparam logic [2:0] SRS_CAUSE_GEN = 3'h0;
  localparam logic [2:0] SRS_CAUSE_WAKE = 3'h1;
  localparam logic [2:0] SRS_CAUSE_WDOG = 3'h2;
  localparam logic [2:0] SRS_CAUSE_SW = 3'h3;
  localparam logic [2:0] SRS_CAUSE_USER = 3'h4;
  // Timing
  localparam int SRS_CORE_HZ = 25_000_000;
  localparam int SRS_SLOW_HZ = 32_768;
  localparam int SRS_SLOW_DIV = SRS_CORE_HZ / SRS_SLOW_HZ;
  localparam int SRS_STARTUP_MS = 1200;
  localparam int SRS_STARTUP_TICKS = SRS_SLOW_HZ * SRS_STARTUP_MS / 1000;
  localparam logic [1:0] SRS_HOLD_TICKS = 2'h2;
  localparam logic [1:0] SRS_SYNC_TICKS = 2'h2;
  localparam logic [1:0] SRS_BOOT_TICKS = 2'h3;
  // Sequencer states
  typedef enum logic [2:0] {
    SRS_ST_BACKUP,
    SRS_ST_WAKE,
    SRS_ST_RUN,
    SRS_ST_USER,
    SRS_ST_SOFT,
    SRS_ST_WDOG,
    SRS_ST_RELEASE
  } srs_state_t;
  // Reset outputs carrier
  typedef struct packed {
    logic cpu_n;
    logic periph_n;
    logic backup_n;
    logic cpu_clk_en;
  } srs_resets_t;
endpackage

// *** rtl/srs_sequencer.sv ***
// Purpose: System reset sequencer with reset pin shaping and cause report
// Assumes: Supplies and pin inputs synchronous to core_clk
// Notes: Slow clock is a one-cycle tick from a core_clk divider
//
// Function
// - Sample reset pin each slow tick, report its level each core clock
// - Pin low resets cpu and periph if enabled
// - Sticky pin-seen flag, cleared by status read
// - Interrupt enable gives interrupt instead of reset
// - Pin pulse lasts two to the power length-plus-one ticks
// - Mode register survives main supply loss
// - Boot select captured three ticks after core power
// - Reset cause updated only at cpu release
// - General reset: startup count, two ticks, release
// - Supply loss asserts resets immediately
// - Wakeup: two ticks clock, release, pin pulse
// - User reset ends after pin high, cause 4
// - Pin held low externally keeps resets asserted during a user reset only
// - Software commands: cpu, periph, pin; two ticks
// - Command write asserts resets at once
// - Software pin pulse starts no user reset
// - Software cause reported only with cpu command
// - Pending flag blocks command writes
// - Watchdog fault: two-tick reset, cpu-only option
// - Priority backup, wakeup, watchdog, software, user
// - Software yields to watchdog, ignores pin
// - Command and mode writes need key 0xA5, watchdog mode writes do not
// - Cause codes general 0 through user 4
// - Interrupt only when user reset disabled
`timescale 1ns/10ps
`default_nettype none
module srs_sequencer
  import srs_pkg::*;
#(
  parameter int STARTUP_TICKS = SRS_STARTUP_TICKS,
  parameter int SLOW_DIV = SRS_SLOW_DIV
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Power and events
  input wire logic backup_supply_ok,
  input wire logic core_supply_ok,
  input wire logic wdog_fault,
  input wire logic boot_select_pin,
  // Reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Reset outputs
  output srs_resets_t resets,
  output logic boot_select,
  output logic user_reset_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Slow tick divider
  logic [15:0] div_r, div_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    div_nxt = div_r + 16'h0001;
    tick_nxt = 1'b0;
    if (div_r == 16'(SLOW_DIV - 1)) begin
      div_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and pin sampling
  logic [7:0] mode_r, mode_nxt;
  logic [1:0] wdmode_r, wdmode_nxt;
  logic seen_r, seen_nxt;
  logic level_r, level_nxt;
  logic [2:0] cause_r, cause_nxt;
  logic pend_r, pend_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] psync_r, psync_nxt;
  logic [3:0] len_r, len_nxt;
  logic uen_r, uien_r;
  logic key_ok, cmd_wr, stat_rd, pin_fall, pin_low_s, pin_own, rel;
  srs_state_t st_r, st_nxt;

  function automatic logic [31:0] read_mux(input logic [1:0] a,
                                           input logic [31:0] st,
                                           input logic [31:0] md,
                                           input logic [31:0] wd);
    case (a)
      2'h1: read_mux = st;
      2'h2: read_mux = md;
      2'h3: read_mux = wd;
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  assign uen_r = mode_r[0];
  assign uien_r = mode_r[1];
  assign key_ok = avs_writedata[31:SRS_KEY_LSB] == SRS_KEY_VAL;
  assign cmd_wr = avs_write && !avs_waitrequest && key_ok &&
                  avs_address == SRS_OFS_CMD[3:2] && !pend_r;
  assign stat_rd = avs_read && !avs_waitrequest &&
                   avs_address == SRS_OFS_STAT[3:2];
  assign pin_fall = psync_r[1] && !reset_pin_in;
  assign pin_low_s = !psync_r[1];

  always_comb begin
    mode_nxt = mode_r;
    wdmode_nxt = wdmode_r;
    seen_nxt = seen_r;
    level_nxt = reset_pin_in;
    psync_nxt = psync_r;
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    if (tick_r) begin
      psync_nxt = {psync_r[0], reset_pin_in};
    end
    if (avs_write && !avs_waitrequest && key_ok &&
        avs_address == SRS_OFS_MODE[3:2]) begin
      mode_nxt = {avs_writedata[11:8], 2'b00,
                  avs_writedata[SRS_MODE_UIEN],
                  avs_writedata[SRS_MODE_UEN]};
    end
    if (avs_write && !avs_waitrequest &&
        avs_address == SRS_OFS_WDOG[3:2]) begin
      wdmode_nxt = avs_writedata[1:0];
    end
    if (stat_rd) begin
      seen_nxt = 1'b0;
    end
    if (pin_fall && !pin_own) begin
      seen_nxt = 1'b1;
    end
    if ((avs_read || avs_write) && !ack_r) begin
      rdata_nxt = read_mux(avs_address,
        {14'h0000, pend_r, level_r, 5'h00, cause_r, 7'h00, seen_r},
        {20'h0_0000, mode_r[7:4], 3'b000, mode_r[1], 3'b000, mode_r[0]},
        {30'h0000_0000, wdmode_r});
    end
  end
  // Mode register sits in backup domain: only backup loss or rst_n clears it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 8'h00;
      wdmode_r <= 2'h1;
    end else if (!backup_supply_ok) begin
      mode_r <= 8'h00;
      wdmode_r <= 2'h1;
    end else begin
      mode_r <= mode_nxt;
      wdmode_r <= wdmode_nxt;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
      level_r <= 1'b1;
      psync_r <= 2'b11;
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      seen_r <= seen_nxt;
      level_r <= level_nxt;
      psync_r <= psync_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign avs_waitrequest = !ack_r;
  assign avs_readdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Reset state machine
  logic [21:0] cnt_r, cnt_nxt;
  logic [16:0] pulse_r, pulse_nxt;
  logic pulse_req;

  // Pulse length in slow ticks, wide enough for the longest setting
  function automatic logic [16:0] pulse_len(input logic [3:0] len);
    pulse_len = 17'h0_0001 << ({1'b0, len} + 5'h01);
  endfunction
  logic pown_r, pown_nxt;
  logic [2:0] pcause_r, pcause_nxt;
  logic upd_r, upd_nxt;
  logic [1:0] bcnt_r, bcnt_nxt;
  logic core_q_r, boot_arm_r, boot_arm_nxt, boot_r, boot_nxt;
  srs_resets_t res_r, res_nxt;
  logic irq_r, irq_nxt;
  logic wd_evt, user_evt;

  assign pin_own = pown_r;
  assign wd_evt = wdog_fault && wdmode_r[SRS_WD_EN];
  assign user_evt = pin_low_s && uen_r && !pown_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pcause_nxt = pcause_r;
    cause_nxt = cause_r;
    pend_nxt = pend_r;
    cmd_nxt = cmd_r;
    upd_nxt = 1'b0;
    pulse_req = 1'b0;
    res_nxt = res_r;
    res_nxt.backup_n = 1'b1;
    if (cmd_wr) begin
      pend_nxt = 1'b1;
      cmd_nxt = {avs_writedata[SRS_CMD_PIN], avs_writedata[SRS_CMD_PER],
                 avs_writedata[SRS_CMD_CPU]};
      if (avs_writedata[SRS_CMD_CPU]) begin
        res_nxt.cpu_n = 1'b0;
      end
      if (avs_writedata[SRS_CMD_PER]) begin
        res_nxt.periph_n = 1'b0;
      end
    end
    if (upd_r) begin
      cause_nxt = pcause_r;
    end
    case (st_r)
      SRS_ST_BACKUP: begin
        res_nxt = '{cpu_n: 1'b0, periph_n: 1'b0, backup_n: 1'b0,
                    cpu_clk_en: 1'b0};
        if (tick_r) begin
          cnt_nxt = cnt_r + 22'h00_0001;
          if (cnt_r >= 22'(STARTUP_TICKS)) begin
            res_nxt.backup_n = 1'b1;
            res_nxt.cpu_clk_en = 1'b1;
            pcause_nxt = SRS_CAUSE_GEN;
            pulse_req = 1'b1;
            cnt_nxt = 22'h00_0000;
            st_nxt = SRS_ST_RELEASE;
          end
        end
      end
      SRS_ST_WAKE: begin
        res_nxt.cpu_n = 1'b0;
        res_nxt.periph_n = 1'b0;
        if (tick_r && core_q_r) begin
          res_nxt.cpu_clk_en = 1'b1;
          pcause_nxt = SRS_CAUSE_WAKE;
          pulse_req = 1'b1;
          cnt_nxt = 22'h00_0000;
          st_nxt = SRS_ST_RELEASE;
        end
      end
      SRS_ST_RUN: begin
        if (wd_evt) begin
          st_nxt = SRS_ST_WDOG;
          cnt_nxt = 22'h00_0000;
          res_nxt.cpu_n = 1'b0;
          res_nxt.periph_n = wdmode_r[SRS_WD_CPU];
          pulse_req = !wdmode_r[SRS_WD_CPU];
          pcause_nxt = SRS_CAUSE_WDOG;
        end else if (cmd_wr) begin
          st_nxt = SRS_ST_SOFT;
          cnt_nxt = 22'h00_0000;
          pulse_req = avs_writedata[SRS_CMD_PIN];
          pcause_nxt = avs_writedata[SRS_CMD_CPU] ? SRS_CAUSE_SW
                                                 : cause_r;
        end else if (tick_r && user_evt) begin
          st_nxt = SRS_ST_USER;
          res_nxt.cpu_n = 1'b0;
          res_nxt.periph_n = 1'b0;
          res_nxt.cpu_clk_en = 1'b0;
          pcause_nxt = SRS_CAUSE_USER;
          pulse_req = 1'b1;
          cnt_nxt = 22'h00_0000;
        end
      end
      SRS_ST_USER: begin
        if (tick_r) begin
          if (pin_low_s || pulse_r != 17'h0_0000) begin
            cnt_nxt = 22'h00_0000;
          end else begin
            res_nxt.cpu_clk_en = 1'b1;
            st_nxt = SRS_ST_RELEASE;
          end
        end
      end
      SRS_ST_SOFT: begin
        if (wd_evt) begin
          st_nxt = SRS_ST_WDOG;
          cnt_nxt = 22'h00_0000;
          res_nxt.cpu_n = 1'b0;
          res_nxt.periph_n = wdmode_r[SRS_WD_CPU];
          pulse_req = !wdmode_r[SRS_WD_CPU];
          pcause_nxt = SRS_CAUSE_WDOG;
        end else if (tick_r) begin
          cnt_nxt = cnt_r + 22'h00_0001;
          if (cnt_r[1:0] == SRS_HOLD_TICKS - 2'h1) begin
            res_nxt.cpu_n = 1'b1;
            res_nxt.periph_n = 1'b1;
            pend_nxt = 1'b0;
            upd_nxt = cmd_r[0];
            st_nxt = SRS_ST_RUN;
          end
        end
      end
      SRS_ST_WDOG: begin
        if (tick_r) begin
          cnt_nxt = cnt_r + 22'h00_0001;
          if (cnt_r[1:0] == SRS_HOLD_TICKS - 2'h1) begin
            res_nxt.cpu_n = 1'b1;
            res_nxt.periph_n = 1'b1;
            pend_nxt = 1'b0;
            upd_nxt = 1'b1;
            st_nxt = SRS_ST_RUN;
          end
        end
      end
      SRS_ST_RELEASE: begin
        if (tick_r) begin
          cnt_nxt = cnt_r + 22'h00_0001;
          if (cnt_r[1:0] == SRS_SYNC_TICKS - 2'h1) begin
            res_nxt.cpu_n = 1'b1;
            res_nxt.periph_n = 1'b1;
            upd_nxt = 1'b1;
            st_nxt = SRS_ST_RUN;
          end
        end
      end
      default: st_nxt = SRS_ST_BACKUP;
    endcase
    if (!core_supply_ok && st_r != SRS_ST_BACKUP) begin
      st_nxt = SRS_ST_WAKE;
      res_nxt.cpu_n = 1'b0;
      res_nxt.periph_n = 1'b0;
      res_nxt.cpu_clk_en = 1'b0;
      pend_nxt = 1'b0;
      upd_nxt = 1'b0;
      pulse_req = 1'b0;
    end
    if (!backup_supply_ok) begin
      st_nxt = SRS_ST_BACKUP;
      cnt_nxt = 22'h00_0000;
      res_nxt = '{cpu_n: 1'b0, periph_n: 1'b0, backup_n: 1'b0,
                  cpu_clk_en: 1'b0};
      pend_nxt = 1'b0;
      upd_nxt = 1'b0;
      pulse_req = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin pulse shaping, boot select, interrupt
  always_comb begin
    pulse_nxt = pulse_r;
    pown_nxt = pown_r;
    if (pulse_req) begin
      pulse_nxt = pulse_len(mode_r[7:4]);
      pown_nxt = 1'b1;
    end else if (tick_r && pulse_r != 17'h0_0000) begin
      pulse_nxt = pulse_r - 17'h0_0001;
    end else if (tick_r && pulse_r == 17'h0_0000 && !pin_low_s) begin
      pown_nxt = 1'b0;
    end
    if (st_r == SRS_ST_WAKE || st_r == SRS_ST_BACKUP) begin
      pulse_nxt = pulse_len(mode_r[7:4]);
      pown_nxt = 1'b1;
    end
    boot_arm_nxt = boot_arm_r;
    bcnt_nxt = bcnt_r;
    boot_nxt = boot_r;
    if (!core_supply_ok) begin
      boot_arm_nxt = 1'b0;
      bcnt_nxt = 2'h0;
    end else if (!core_q_r) begin
      boot_arm_nxt = 1'b1;
    end else if (boot_arm_r && tick_r) begin
      bcnt_nxt = bcnt_r + 2'h1;
      if (bcnt_r == SRS_BOOT_TICKS - 2'h1) begin
        boot_nxt = boot_select_pin;
        boot_arm_nxt = 1'b0;
      end
    end
    irq_nxt = seen_nxt && !uen_r && uien_r;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= SRS_ST_BACKUP;
      cnt_r <= 22'h00_0000;
      cause_r <= SRS_CAUSE_GEN;
      pcause_r <= SRS_CAUSE_GEN;
      pend_r <= 1'b0;
      cmd_r <= 3'h0;
      upd_r <= 1'b0;
      res_r <= '{cpu_n: 1'b0, periph_n: 1'b0, backup_n: 1'b0,
                 cpu_clk_en: 1'b0};
      pulse_r <= 17'h0_0002;
      pown_r <= 1'b1;
      core_q_r <= 1'b0;
      boot_arm_r <= 1'b0;
      bcnt_r <= 2'h0;
      boot_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cause_r <= cause_nxt;
      pcause_r <= pcause_nxt;
      pend_r <= pend_nxt;
      cmd_r <= cmd_nxt;
      upd_r <= upd_nxt;
      res_r <= res_nxt;
      pulse_r <= pulse_nxt;
      pown_r <= pown_nxt;
      core_q_r <= tick_r ? core_supply_ok : core_q_r;
      boot_arm_r <= boot_arm_nxt;
      bcnt_r <= bcnt_nxt;
      boot_r <= boot_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign resets = res_r;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = pulse_r != 17'h0_0000;
  assign boot_select = boot_r;
  assign user_reset_irq = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_bad_key;
    avs_write && !avs_waitrequest && !key_ok &&
    avs_address == SRS_OFS_MODE[3:2];
  endsequence
  chk_key_guard: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_bad_key |=> $stable(mode_r)) else $error("mode changed on bad key");
  chk_cause_only_release: assert property (@(posedge core_clk)
    disable iff (!rst_n) $changed(cause_r) |-> $past(upd_r))
    else $error("cause moved outside release");
  chk_seen_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_fall && !pin_own |=> seen_r) else $error("pin fall lost");
  chk_irq_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    user_reset_irq |-> !uen_r || $past(!uen_r))
    else $error("irq with reset enabled");
  chk_cmd_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_wr |=> pend_r) else $error("pending flag not set");
  chk_backup_loss: assert property (@(posedge core_clk) disable iff (!rst_n)
    !backup_supply_ok |=> !resets.backup_n && !resets.cpu_n)
    else $error("backup loss not honoured");
  chk_cmd_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_wr && avs_writedata[SRS_CMD_CPU] && backup_supply_ok &&
    core_supply_ok |=> !resets.cpu_n) else $error("cpu cmd slow");
  chk_pin_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    pulse_req |=> reset_pin_oe) else $error("pin pulse missing");

endmodule
`default_nettype wire

// *** testbench/srs_board_model.sv ***
// Purpose: Board device sharing the reset pin
// Assumes: Pin has a pull-up, every party drives it open drain
// Notes: hold_low lets the bench keep the pin down for any time
`timescale 1ns/10ps
`default_nettype none
module srs_board_model (
  // Pin drivers
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic hold_low,
  // Resolved pin
  output logic pin_level
);
  // Pull-up unless some party pulls low
  assign pin_level = !((pin_oe && !pin_out) || hold_low);
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Short startup and slow tick divider parameters
// Notes: Bus tasks hold each request until waitrequest is low
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import srs_pkg::*;
;
  localparam int DIV = 4;
  localparam int LIMIT = 20000;
  logic core_clk;
  logic rst_n;
  logic [1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic backup_supply_ok;
  logic core_supply_ok;
  logic wdog_fault;
  logic boot_select_pin;
  logic pin_level;
  logic pin_out;
  logic pin_oe;
  logic hold_low;
  srs_resets_t resets;
  logic boot_select;
  logic user_reset_irq;
  logic [31:0] rd;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int oe_cnt = 0;
  int o0;
  ////////////////////////////////////////////////////////////////////////////
  srs_sequencer #(.STARTUP_TICKS(4), .SLOW_DIV(DIV)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .backup_supply_ok(backup_supply_ok), .core_supply_ok(core_supply_ok),
    .wdog_fault(wdog_fault), .boot_select_pin(boot_select_pin),
    .reset_pin_in(pin_level), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .resets(resets), .boot_select(boot_select),
    .user_reset_irq(user_reset_irq)
  );
  srs_board_model board (
    .pin_oe(pin_oe), .pin_out(pin_out), .hold_low(hold_low),
    .pin_level(pin_level)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end
  // Slow ticks with the pin driven low
  always @(negedge core_clk) begin
    if (pin_oe === 1'b1 && DUT.tick_r === 1'b1) begin
      oe_cnt++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      n++;
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("bus answer", 32'h0000_0000, {31'h0000_0000, n >= 100});
  endtask
  task automatic flag(input string what, input logic e, input logic g);
    chk(what, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  task automatic chk_st(input logic [2:0] c);
    bus(1'b0, 2'h1, 32'h0000_0000);
    chk("cause", {29'h0000_0000, c}, {29'h0000_0000, rd[10:8]});
  endtask
  task automatic wait_cpu(input logic v);
    int n;
    n = 0;
    while (resets.cpu_n !== v && n < 500) begin
      n++;
      @(negedge core_clk);
    end
    flag("cpu_n wait", v, resets.cpu_n);
  endtask
  task automatic chk_mode(input logic [31:0] e);
    bus(1'b0, 2'h2, 32'h0000_0000);
    chk("mode", e, rd & 32'h0000_0F11);
  endtask
  task automatic hold_pin(input int n);
    @(posedge core_clk);
    hold_low <= 1'b1;
    repeat (n) @(negedge core_clk);
    @(posedge core_clk);
    hold_low <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    backup_supply_ok = 1'b1;
    core_supply_ok = 1'b1;
    wdog_fault = 1'b0;
    boot_select_pin = 1'b1;
    hold_low = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_cpu(1'b1);
    flag("boot", 1'b1, boot_select);
    chk_st(SRS_CAUSE_GEN);
    chk_mode(32'h0000_0000);
    $display("test general done");
    bus(1'b1, 2'h2, 32'h5A00_0111);
    chk_mode(32'h0000_0000);
    bus(1'b1, 2'h2, 32'hA500_0101);
    chk_mode(32'h0000_0101);
    $display("test key done");
    o0 = oe_cnt;
    bus(1'b1, 2'h0, 32'hA500_0005);
    bus(1'b1, 2'h0, 32'hA500_0008);
    flag("cpu_n sw", 1'b0, resets.cpu_n);
    flag("periph_n sw", 1'b0, resets.periph_n);
    bus(1'b0, 2'h1, 32'h0000_0000);
    flag("pending", 1'b1, rd[17]);
    wait_cpu(1'b1);
    chk_st(SRS_CAUSE_SW);
    flag("pending end", 1'b0, rd[17]);
    chk("ignored cmd", 32'(o0), 32'(oe_cnt));
    $display("test software done");
    o0 = oe_cnt;
    bus(1'b1, 2'h0, 32'hA500_0008);
    repeat (2) @(negedge core_clk);
    flag("cpu_n pin cmd", 1'b1, resets.cpu_n);
    repeat (40) @(negedge core_clk);
    chk("pulse", 32'(4), 32'(oe_cnt - o0));
    chk_st(SRS_CAUSE_SW);
    $display("test pin command done");
    hold_pin(60);
    flag("cpu_n user", 1'b0, resets.cpu_n);
    flag("periph_n user", 1'b0, resets.periph_n);
    bus(1'b0, 2'h1, 32'h0000_0000);
    flag("seen", 1'b1, rd[0]);
    wait_cpu(1'b1);
    chk_st(SRS_CAUSE_USER);
    flag("level", 1'b1, rd[16]);
    $display("test user done");
    bus(1'b1, 2'h2, 32'hA500_0110);
    bus(1'b0, 2'h1, 32'h0000_0000);
    hold_pin(20);
    repeat (2) @(negedge core_clk);
    flag("irq", 1'b1, user_reset_irq);
    flag("cpu_n irq", 1'b1, resets.cpu_n);
    bus(1'b0, 2'h1, 32'h0000_0000);
    flag("seen irq", 1'b1, rd[0]);
    repeat (2) @(negedge core_clk);
    flag("irq clear", 1'b0, user_reset_irq);
    bus(1'b0, 2'h1, 32'h0000_0000);
    flag("seen clear", 1'b0, rd[0]);
    $display("test interrupt done");
    bus(1'b1, 2'h2, 32'hA500_0101);
    o0 = oe_cnt;
    @(posedge core_clk);
    wdog_fault <= 1'b1;
    wait_cpu(1'b0);
    @(posedge core_clk);
    wdog_fault <= 1'b0;
    @(negedge core_clk);
    flag("periph_n wdog", 1'b0, resets.periph_n);
    wait_cpu(1'b1);
    repeat (40) @(negedge core_clk);
    chk("wdog pulse", 32'(4), 32'(oe_cnt - o0));
    chk_st(SRS_CAUSE_WDOG);
    $display("test watchdog done");
    @(posedge core_clk);
    core_supply_ok <= 1'b0;
    boot_select_pin <= 1'b0;
    repeat (12) @(negedge core_clk);
    flag("cpu_n wake", 1'b0, resets.cpu_n);
    flag("backup_n wake", 1'b1, resets.backup_n);
    @(posedge core_clk);
    core_supply_ok <= 1'b1;
    wait_cpu(1'b1);
    flag("boot wake", 1'b0, boot_select);
    chk_st(SRS_CAUSE_WAKE);
    chk_mode(32'h0000_0101);
    $display("test wakeup done");
    @(posedge core_clk);
    backup_supply_ok <= 1'b0;
    repeat (8) @(negedge core_clk);
    flag("backup_n lost", 1'b0, resets.backup_n);
    flag("cpu_n lost", 1'b0, resets.cpu_n);
    @(posedge core_clk);
    backup_supply_ok <= 1'b1;
    wait_cpu(1'b1);
    chk_st(SRS_CAUSE_GEN);
    chk_mode(32'h0000_0000);
    $display("test backup done");
    complete_run();
  end
endmodule
`default_nettype wire
